/* logic/sipp_top.v */
// Behaviour
// - Only enable instruction works until enabled
// - Sample on rising, shift out on falling
// - Chip erase sets Flash and EEPROM ones
// - Echo second enable byte during third
// - Page write commits buffer to page
// - EEPROM byte write erases then writes
// - EEPROM page write touches loaded bytes only
// - EEPROM page write stores page buffer
// - Reads return data in fourth byte
// - Page load opcodes and word addressing
// - Flash and EEPROM read opcodes
// - Fuse and lock writes, zero programmed
// - Fuse, lock, signature, calibration reads
// - Extended address byte latched
// - Poll returns busy in bit zero
`timescale 1ns/1ps
`include "sipp_regs.vh"
module sipp_top #(
   parameter [`SIPP_CNT_W-1:0] FLASH_WAIT_CYC  = `SIPP_FLASH_WAIT_US * `SIPP_CLK_MHZ,
   parameter [`SIPP_CNT_W-1:0] EEPROM_WAIT_CYC = `SIPP_EEPROM_WAIT_US * `SIPP_CLK_MHZ,
   parameter [`SIPP_CNT_W-1:0] ERASE_WAIT_CYC  = `SIPP_ERASE_WAIT_US * `SIPP_CLK_MHZ,
   parameter [`SIPP_CNT_W-1:0] FUSE_WAIT_CYC   = `SIPP_FUSE_WAIT_US * `SIPP_CLK_MHZ,
   parameter [7:0]             LFUSE_RST       = 8'hff, // Arbitrary value
   parameter [7:0]             HFUSE_RST       = 8'hff, // Arbitrary value
   parameter [7:0]             EFUSE_RST       = 8'hff, // Arbitrary value
   parameter [7:0]             LOCK_RST        = 8'hff, // Arbitrary value
   parameter [7:0]             SIG0            = 8'h11, // Arbitrary value
   parameter [7:0]             SIG1            = 8'h22, // Arbitrary value
   parameter [7:0]             SIG2            = 8'h33, // Arbitrary value
   parameter [7:0]             CAL_BYTE        = 8'h80  // Arbitrary value
) (
   input  wire       i_clk,          // System clock, 50 MHz
   input  wire       i_reset,        // Async reset, active high
   input  wire       i_rst_n,        // Device reset pin, low selects programming
   input  wire       i_sck,          // Serial clock pin
   input  wire       i_mosi,         // Serial data in pin
   output reg        o_miso,         // Serial data out pin
   output reg        o_miso_oe,      // MISO driven while programming
   output reg        o_prog_enabled, // Programming enabled
   output reg        o_busy,         // Write operation pending
   output reg  [7:0] o_ext_addr,     // Latched extended address
   output reg        o_overrun       // Byte lost, buffer was full
);
   // Pin synchronisers
   reg rst_s1, rst_s2;           // Reset pin sync
   reg sck_s1, sck_s2, sck_s3;   // Clock sync and history
   reg mosi_s1, mosi_s2;         // Data sync
   wire prog_mode = ~rst_s2;     // Programming mode active
   wire sck_rise  = sck_s2 & ~sck_s3;
   wire sck_fall  = ~sck_s2 & sck_s3;

   // Serial side state
   reg  [2:0] bit_cnt;           // Bit within byte
   reg  [1:0] byte_idx;          // Byte within frame
   reg  [7:0] shreg;             // Receive shift
   reg  [7:0] tx;                // Transmit shift
   reg  [7:0] pb1, pb2;          // Frame bytes for read lookup
   reg        push;              // Byte into buffer
   reg  [7:0] push_byte;         // Byte value
   wire [7:0] rx_byte = {shreg[6:0], mosi_s2};
   wire       buf_ready;         // Buffer accepts
   wire       buf_valid;         // Buffer holds a byte
   wire [7:0] buf_data;          // Buffer head

   // Interpreter state
   reg  [1:0] state;             // Interpreter state
   reg  [1:0] iidx;              // Byte within frame
   reg  [7:0] ib1, ib2, ib3;     // Collected bytes
   reg        enabled;           // Programming enabled
   reg  [`SIPP_CNT_W-1:0] busy_cnt;   // Self-timed wait
   reg  [`SIPP_PAGE_AW-1:0] cp_cnt;   // Page copy index
   reg  [`SIPP_FLASH_AW-`SIPP_PAGE_AW-1:0] cp_page; // Target page
   reg  [`SIPP_FLASH_AW-1:0] er_ptr;  // Erase walk pointer
   reg  [7:0] lfuse, hfuse, efuse, lock; // Fuse and lock bytes
   wire       pop = buf_valid & (state == `SIPP_ST_IDLE);
   wire       busy_now = (busy_cnt != {`SIPP_CNT_W{1'b0}}) | (state != `SIPP_ST_IDLE);
   wire [15:0]               wfull = {ib2, ib3};   // Full two-byte word address
   wire [`SIPP_FLASH_AW-1:0] waddr = wfull[`SIPP_FLASH_AW-1:0];
   wire [`SIPP_EE_AW-1:0]    eaddr = {ib2[1:0], ib3};

   // Memories and page buffers
   reg [7:0] flash_hi [0:(1<<`SIPP_FLASH_AW)-1];
   reg [7:0] flash_lo [0:(1<<`SIPP_FLASH_AW)-1];
   reg [7:0] eeprom   [0:(1<<`SIPP_EE_AW)-1];
   reg [7:0] pbuf_hi  [0:(1<<`SIPP_PAGE_AW)-1];
   reg [7:0] pbuf_lo  [0:(1<<`SIPP_PAGE_AW)-1];
   reg [7:0] eebuf    [0:`SIPP_EEPG_N-1];
   reg [`SIPP_EEPG_N-1:0] ee_loaded;  // Page buffer slots loaded
   integer k;

   // Read lookup for the byte returned in the fourth slot
   function [7:0] read_byte;
      input [7:0] b1;
      input [7:0] b2;
      input [7:0] b3;
      reg   [15:0] full; // Two-byte word address
      begin
         full = {b2, b3};
         case (b1)
            `SIPP_OP_RDHI:   read_byte = flash_hi[full[`SIPP_FLASH_AW-1:0]];
            `SIPP_OP_RDLO:   read_byte = flash_lo[full[`SIPP_FLASH_AW-1:0]];
            `SIPP_OP_EERD:   read_byte = eeprom[{b2[1:0], b3}];
            `SIPP_OP_RDLOCK: read_byte = (b2 == `SIPP_SEL_HIGH) ? hfuse : lock;
            `SIPP_OP_RDFUSE: read_byte = (b2 == `SIPP_SEL_HIGH) ? efuse : lfuse;
            `SIPP_OP_RDCAL:  read_byte = CAL_BYTE;
            `SIPP_OP_RDSIG: begin
               case (b3[1:0])
                  2'h0:    read_byte = SIG0;
                  2'h1:    read_byte = SIG1;
                  2'h2:    read_byte = SIG2;
                  default: read_byte = `SIPP_ERASED;
               endcase
            end
            `SIPP_OP_POLL:   read_byte = {7'h00, o_busy};
            default:         read_byte = 8'h00;
         endcase
      end
   endfunction

   // Two-flop synchronisers for the three pins
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rst_s1  <= 1'b1;
         rst_s2  <= 1'b1;
         sck_s1  <= 1'b0;
         sck_s2  <= 1'b0;
         sck_s3  <= 1'b0;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end else begin
         rst_s1  <= i_rst_n;
         rst_s2  <= rst_s1;
         sck_s1  <= i_sck;
         sck_s2  <= sck_s1;
         sck_s3  <= sck_s2;
         mosi_s1 <= i_mosi;
         mosi_s2 <= mosi_s1;
      end
   end

   // Serial shifter, framing and MISO
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         bit_cnt   <= 3'h0;
         byte_idx  <= 2'h0;
         shreg     <= 8'h00;
         tx        <= 8'h00;
         pb1       <= 8'h00;
         pb2       <= 8'h00;
         push      <= 1'b0;
         push_byte <= 8'h00;
         o_miso    <= 1'b0;
         o_miso_oe <= 1'b0;
         o_overrun <= 1'b0;
      end else begin
         o_miso_oe <= prog_mode;
         push      <= 1'b0;
         if (push & ~buf_ready) begin
            o_overrun <= 1'b1;
         end
         if (!prog_mode) begin
            // Reset pin high ends session and restarts framing
            bit_cnt  <= 3'h0;
            byte_idx <= 2'h0;
            tx       <= 8'h00;
            o_miso   <= 1'b0;
         end else if (sck_rise) begin
            shreg   <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `SIPP_LAST_BIT) begin
               push      <= 1'b1;
               push_byte <= rx_byte;
               byte_idx  <= byte_idx + 2'h1;
               if (byte_idx == 2'h0) begin
                  pb1 <= rx_byte;
               end
               if (byte_idx == 2'h1) begin
                  pb2 <= rx_byte;
               end
               if (byte_idx == `SIPP_BYTE3 && enabled) begin
                  tx <= read_byte(pb1, pb2, rx_byte);
               end else begin
                  tx <= rx_byte;
               end
            end
         end else if (sck_fall) begin
            o_miso <= tx[7];
            tx     <= {tx[6:0], 1'b0};
         end
      end
   end

   sipp_byte_buffer #(
      .WIDTH (8),
      .DEPTH (2),
      .AW    (1)
   ) u_buf (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_clear (~prog_mode),
      .i_valid (push),
      .o_ready (buf_ready),
      .i_data  (push_byte),
      .o_valid (buf_valid),
      .i_ready (state == `SIPP_ST_IDLE),
      .o_data  (buf_data)
   );

   // Memory writes: page loads, commits, erase walk
   always @(posedge i_clk) begin
      if (state == `SIPP_ST_FCOPY) begin
         flash_hi[{cp_page, cp_cnt}] <= pbuf_hi[cp_cnt];
         flash_lo[{cp_page, cp_cnt}] <= pbuf_lo[cp_cnt];
      end else if (state == `SIPP_ST_ERASE) begin
         flash_hi[er_ptr] <= `SIPP_ERASED;
         flash_lo[er_ptr] <= `SIPP_ERASED;
         eeprom[er_ptr[`SIPP_EE_AW-1:0]] <= `SIPP_ERASED;
      end else if (pop && iidx == `SIPP_LAST_BYTE && enabled) begin
         case (ib1)
            `SIPP_OP_LDHI: pbuf_hi[ib3[`SIPP_PAGE_AW-1:0]] <= buf_data;
            `SIPP_OP_LDLO: pbuf_lo[ib3[`SIPP_PAGE_AW-1:0]] <= buf_data;
            `SIPP_OP_EELD: eebuf[ib3[`SIPP_EEPG_AW-1:0]] <= buf_data;
            `SIPP_OP_EEWR: begin
               // Self-timed erase then write collapses to one store
               if (!busy_now) begin
                  eeprom[eaddr] <= buf_data;
               end
            end
            `SIPP_OP_EEPG: begin
               if (!busy_now) begin
                  for (k = 0; k < `SIPP_EEPG_N; k = k + 1) begin
                     if (ee_loaded[k]) begin
                        eeprom[{eaddr[`SIPP_EE_AW-1:`SIPP_EEPG_AW], k[1:0]}] <= eebuf[k];
                     end
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Instruction interpreter and self-timed busy
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state          <= `SIPP_ST_IDLE;
         iidx           <= 2'h0;
         ib1            <= 8'h00;
         ib2            <= 8'h00;
         ib3            <= 8'h00;
         enabled        <= 1'b0;
         busy_cnt       <= {`SIPP_CNT_W{1'b0}};
         cp_cnt         <= {`SIPP_PAGE_AW{1'b0}};
         cp_page        <= {(`SIPP_FLASH_AW-`SIPP_PAGE_AW){1'b0}};
         er_ptr         <= {`SIPP_FLASH_AW{1'b0}};
         ee_loaded      <= {`SIPP_EEPG_N{1'b0}};
         lfuse          <= LFUSE_RST;
         hfuse          <= HFUSE_RST;
         efuse          <= EFUSE_RST;
         lock           <= LOCK_RST;
         o_ext_addr     <= 8'h00;
         o_prog_enabled <= 1'b0;
         o_busy         <= 1'b0;
      end else begin
         o_busy         <= busy_now;
         o_prog_enabled <= enabled;
         if (busy_cnt != {`SIPP_CNT_W{1'b0}}) begin
            busy_cnt <= busy_cnt - 1'b1;
         end
         case (state)
            `SIPP_ST_FCOPY: begin
               cp_cnt <= cp_cnt + 1'b1;
               if (cp_cnt == `SIPP_PAGE_LAST) begin
                  state <= `SIPP_ST_IDLE;
               end
            end
            `SIPP_ST_ERASE: begin
               er_ptr <= er_ptr + 1'b1;
               if (er_ptr == `SIPP_ERASE_LAST) begin
                  state <= `SIPP_ST_IDLE;
               end
            end
            default: begin
               if (!prog_mode) begin
                  enabled <= 1'b0;
                  iidx    <= 2'h0;
               end else if (pop) begin
                  iidx <= iidx + 2'h1;
                  if (iidx == 2'h0) begin
                     ib1 <= buf_data;
                  end
                  if (iidx == 2'h1) begin
                     ib2 <= buf_data;
                  end
                  if (iidx == `SIPP_BYTE3) begin
                     ib3 <= buf_data;
                  end
                  if (iidx == `SIPP_LAST_BYTE) begin
                     if (ib1 == `SIPP_OP_MULTI && ib2 == `SIPP_SUB_ENABLE) begin
                        enabled <= 1'b1;
                     end else if (enabled) begin
                        case (ib1)
                           `SIPP_OP_EXTADR: o_ext_addr <= ib3;
                           `SIPP_OP_EELD: ee_loaded[ib3[`SIPP_EEPG_AW-1:0]] <= 1'b1;
                           `SIPP_OP_WRPAGE: begin
                              if (!busy_now) begin
                                 cp_page  <= waddr[`SIPP_FLASH_AW-1:`SIPP_PAGE_AW];
                                 cp_cnt   <= {`SIPP_PAGE_AW{1'b0}};
                                 state    <= `SIPP_ST_FCOPY;
                                 busy_cnt <= FLASH_WAIT_CYC;
                              end
                           end
                           `SIPP_OP_EEWR: begin
                              if (!busy_now) begin
                                 busy_cnt <= EEPROM_WAIT_CYC;
                              end
                           end
                           `SIPP_OP_EEPG: begin
                              if (!busy_now) begin
                                 ee_loaded <= {`SIPP_EEPG_N{1'b0}};
                                 busy_cnt  <= EEPROM_WAIT_CYC;
                              end
                           end
                           `SIPP_OP_MULTI: begin
                              if (!busy_now) begin
                                 case (ib2)
                                    `SIPP_SUB_ERASE: begin
                                       er_ptr   <= {`SIPP_FLASH_AW{1'b0}};
                                       state    <= `SIPP_ST_ERASE;
                                       lock     <= `SIPP_ERASED;
                                       busy_cnt <= ERASE_WAIT_CYC;
                                    end
                                    `SIPP_SUB_LOCK: begin
                                       lock     <= lock & buf_data;
                                       busy_cnt <= FUSE_WAIT_CYC;
                                    end
                                    `SIPP_SUB_FLOW: begin
                                       lfuse    <= buf_data;
                                       busy_cnt <= FUSE_WAIT_CYC;
                                    end
                                    `SIPP_SUB_FHIGH: begin
                                       hfuse    <= buf_data;
                                       busy_cnt <= FUSE_WAIT_CYC;
                                    end
                                    `SIPP_SUB_FEXT: begin
                                       efuse    <= buf_data;
                                       busy_cnt <= FUSE_WAIT_CYC;
                                    end
                                    default: begin
                                    end
                                 endcase
                              end
                           end
                           default: begin
                           end
                        endcase
                     end
                  end
               end
            end
         endcase
         // Session end clears enable even during a copy or erase walk
         if (!prog_mode) begin
            enabled <= 1'b0;
            iidx    <= 2'h0;
         end
      end
   end
endmodule

/* logic/sipp_regs.vh */
`ifndef SIPP_REGS_VH
`define SIPP_REGS_VH
// First-byte opcodes
`define SIPP_OP_MULTI   8'hac
`define SIPP_OP_POLL    8'hf0
`define SIPP_OP_EXTADR  8'h4d
`define SIPP_OP_LDHI    8'h48
`define SIPP_OP_LDLO    8'h40
`define SIPP_OP_EELD    8'hc1
`define SIPP_OP_RDHI    8'h28
`define SIPP_OP_RDLO    8'h20
`define SIPP_OP_EERD    8'ha0
`define SIPP_OP_RDLOCK  8'h58
`define SIPP_OP_RDFUSE  8'h50
`define SIPP_OP_RDSIG   8'h30
`define SIPP_OP_RDCAL   8'h38
`define SIPP_OP_WRPAGE  8'h4c
`define SIPP_OP_EEWR    8'hc0
`define SIPP_OP_EEPG    8'hc2
// Second-byte selectors
`define SIPP_SUB_ENABLE 8'h53
`define SIPP_SUB_ERASE  8'h80
`define SIPP_SUB_LOCK   8'he0
`define SIPP_SUB_FLOW   8'ha0
`define SIPP_SUB_FHIGH  8'ha8
`define SIPP_SUB_FEXT   8'ha4
`define SIPP_SEL_HIGH   8'h08
// Memory geometry
`define SIPP_FLASH_AW   13
`define SIPP_PAGE_AW    6
`define SIPP_EE_AW      10
`define SIPP_EEPG_AW    2
`define SIPP_EEPG_N     4
`define SIPP_PAGE_LAST  6'h3f
`define SIPP_ERASE_LAST 13'h1fff
`define SIPP_ERASED     8'hff
// Framing
`define SIPP_LAST_BIT   3'h7
`define SIPP_BYTE3      2'h2
`define SIPP_LAST_BYTE  2'h3
// Timing
`define SIPP_CLK_MHZ        50
`define SIPP_FLASH_WAIT_US  4500
`define SIPP_EEPROM_WAIT_US 3600
`define SIPP_ERASE_WAIT_US  9000
`define SIPP_FUSE_WAIT_US   4500
`define SIPP_CNT_W          20
// Interpreter states
`define SIPP_ST_IDLE    2'h0
`define SIPP_ST_FCOPY   2'h1
`define SIPP_ST_ERASE   2'h2
`endif

/* logic/sipp_byte_buffer.v */
`timescale 1ns/1ps
// Small FIFO between the serial side and the instruction interpreter
module sipp_byte_buffer #(
   parameter WIDTH = 8,
   parameter DEPTH = 2,
   parameter AW    = 1
) (
   input  wire             i_clk,   // System clock
   input  wire             i_reset, // Async reset, active high
   input  wire             i_clear, // Synchronous flush
   input  wire             i_valid, // Fill side valid
   output wire             o_ready, // Fill side ready
   input  wire [WIDTH-1:0] i_data,  // Fill side data
   output wire             o_valid, // Drain side valid
   input  wire             i_ready, // Drain side ready
   output wire [WIDTH-1:0] o_data   // Drain side data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
   reg [AW-1:0]    wr_ptr;          // Write pointer
   reg [AW-1:0]    rd_ptr;          // Read pointer
   reg [AW:0]      count;           // Fill level
   wire            do_wr;           // Accepted write
   wire            do_rd;           // Accepted read

   assign o_ready = (count != DEPTH[AW:0]);
   assign o_valid = (count != {(AW+1){1'b0}});
   assign o_data  = mem[rd_ptr];
   assign do_wr   = i_valid & o_ready;
   assign do_rd   = o_valid & i_ready;

   // Storage write, no reset needed
   always @(posedge i_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= i_data;
      end
   end

   // Pointers and level
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else if (i_clear) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd & ~do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

/* tb/sipp_properties.sv */
`timescale 1ns/1ps
// Pin-level checks of the programming port
module sipp_properties #(
   parameter [19:0] FLASH_WAIT_CYC  = 20'd200,
   parameter [19:0] EEPROM_WAIT_CYC = 20'd150,
   parameter [19:0] ERASE_WAIT_CYC  = 20'd9000,
   parameter [19:0] FUSE_WAIT_CYC   = 20'd200
) (
   input wire       i_clk,          // Clock
   input wire       i_reset,        // Reset
   input wire       i_rst_n,        // Session pin
   input wire       i_sck,          // Serial clock
   input wire       i_mosi,         // Serial in
   input wire       o_miso,         // Serial out
   input wire       o_miso_oe,      // Out enable
   input wire       o_prog_enabled, // Enabled
   input wire       o_busy,         // Busy
   input wire [7:0] o_ext_addr,     // Extended address
   input wire       o_overrun       // Overrun
);
   reg        sck_q;    // Sampled serial clock
   reg [3:0]  fall_age; // Cycles since clock fell
   reg [19:0] busy_cnt; // Busy period length
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Fall age and busy length
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sck_q <= 1'b0;
         fall_age <= 4'hf;
         busy_cnt <= 20'h0;
      end else begin
         sck_q <= i_sck;
         fall_age <= (sck_q && !i_sck) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
         busy_cnt <= o_busy ? busy_cnt + 20'h1 : 20'h0;
      end
   end
   enab_clear_a: assert property (i_rst_n [*4] |=> !o_prog_enabled)
      else $error("enable kept after session end");
   oe_off_a: assert property (i_rst_n [*4] |=> !o_miso_oe)
      else $error("output driven outside session");
   oe_on_a: assert property (!i_rst_n [*4] |=> o_miso_oe)
      else $error("output not driven in session");
   enab_oe_a: assert property ($rose(o_prog_enabled) |-> o_miso_oe)
      else $error("enabled outside session");
   busy_gate_a: assert property ($rose(o_busy) |-> $past(o_prog_enabled))
      else $error("write started before enable");
   miso_shift_a: assert property (o_miso_oe && !i_rst_n && $changed(o_miso)
      |-> fall_age inside {[1:6]}) else $error("output moved away from falling edge");
   busy_len_a: assert property ($fell(o_busy) |-> busy_cnt inside
      {[FLASH_WAIT_CYC-1:FLASH_WAIT_CYC+1], [EEPROM_WAIT_CYC-1:EEPROM_WAIT_CYC+1],
      [ERASE_WAIT_CYC-1:ERASE_WAIT_CYC+1], [FUSE_WAIT_CYC-1:FUSE_WAIT_CYC+1]})
      else $error("busy length wrong");
   ext_gate_a: assert property ($changed(o_ext_addr) |-> o_prog_enabled)
      else $error("extended address taken before enable");
   ovr_sticky_a: assert property (o_overrun |=> o_overrun)
      else $error("overrun flag dropped");
   cover property ($rose(o_prog_enabled));
   cover property ($fell(o_busy));
   cover property ($rose(o_overrun));
endmodule
bind sipp_top sipp_properties #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC),
   .EEPROM_WAIT_CYC(EEPROM_WAIT_CYC), .ERASE_WAIT_CYC(ERASE_WAIT_CYC),
   .FUSE_WAIT_CYC(FUSE_WAIT_CYC)) u_props (.i_clk(i_clk), .i_reset(i_reset),
   .i_rst_n(i_rst_n), .i_sck(i_sck), .i_mosi(i_mosi), .o_miso(o_miso),
   .o_miso_oe(o_miso_oe), .o_prog_enabled(o_prog_enabled), .o_busy(o_busy),
   .o_ext_addr(o_ext_addr), .o_overrun(o_overrun));

/* tb/sipp_prog_model.sv */
`timescale 1ns/1ps
// Programmer side of the link, clock low between frames
module sipp_prog_model (
   input  wire        i_clk,     // Clock
   input  wire        i_miso,    // Data from device
   output reg         o_sck,     // Serial clock
   output reg         o_mosi,    // Serial data out
   output reg         o_got,     // Frame done pulse
   output reg  [15:0] o_got_data // Bytes 3 and 4 returned
);
   integer n; // Bit index
   // Idle levels at time zero
   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b0;
      o_got = 1'b0;
      o_got_data = 16'h0;
   end
   // One frame, four clocks per phase
   task xfer(input [31:0] f, output [15:0] r);
      begin
         @(posedge i_clk);
         for (n = 31; n >= 0; n = n - 1) begin
            o_mosi <= f[n];
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            if (n < 16) r[n] = i_miso;
            o_sck <= 1'b0;
         end
         o_got <= 1'b1;
         o_got_data <= r;
         @(posedge i_clk);
         o_got <= 1'b0;
      end
   endtask
endmodule

/* tb/test_serial_isp_programming_port.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_serial_isp_programming_port;
   reg         clk, reset, rst_n;   // Clock, resets
   wire        sck, mosi, miso, oe; // Link pins
   wire        enab, busy, ovr, got; // Status
   wire [7:0]  ext;                 // Extended address
   wire [15:0] gd;                  // Returned bytes
   reg  [31:0] q [$];               // Expected {mask, value}
   reg  [31:0] ent;                 // Oldest note
   reg  [15:0] rd, a, d;            // Reply, address, data
   reg  [7:0]  v;                   // Byte value
   integer     errors, total_checks, seed, cyc, i, n;
   sipp_top #(.FLASH_WAIT_CYC(20'd2000), .EEPROM_WAIT_CYC(20'd1500),
      .ERASE_WAIT_CYC(20'd9000), .FUSE_WAIT_CYC(20'd2000)) i_dut (.i_clk(clk),
      .i_reset(reset), .i_rst_n(rst_n), .i_sck(sck), .i_mosi(mosi), .o_miso(miso),
      .o_miso_oe(oe), .o_prog_enabled(enab), .o_busy(busy), .o_ext_addr(ext),
      .o_overrun(ovr));
   sipp_prog_model i_prog (.i_clk(clk), .i_miso(miso), .o_sck(sck), .o_mosi(mosi),
      .o_got(got), .o_got_data(gd));
   // Clock and timeout
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 80000) begin
         errors++;
         give_verdict;
      end
      if (got) begin
         ent = q.pop_front();
         if (ent[31:16] != 16'h0) `CHK(gd & ent[31:16], ent[15:0])
      end
   end
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // Note expectation, then send frame
   task fr(input [31:0] f, input [15:0] m, input [15:0] e);
      begin
         q.push_back({m, e});
         i_prog.xfer(f, rd);
      end
   endtask
   // Poll until idle; first answer busy
   task poll;
      begin
         fr(32'hf0000000, 16'h0001, 16'h0001);
         for (n = 0; n < 100 && rd[0] !== 1'b0; n++)
            fr(32'hf0000000, 16'h0, 16'h0);
         `CHK(rd[0], 1'b0)
      end
   endtask
   // Main sequence
   initial begin
      seed = 3;
      errors = 0;
      total_checks = 0;
      cyc = 0;
      reset = 1'b1;
      rst_n = 1'b0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (100) @(posedge clk);
      fr(32'h20005a00, 16'h00ff, 16'h005a);
      fr(32'hac800000, 16'h0, 16'h0);
      repeat (8) @(posedge clk);
      `CHK({enab, busy}, 2'b00)
      fr(32'hac530000, 16'hff00, 16'h5300);
      repeat (8) @(posedge clk);
      `CHK(enab, 1'b1)
      fr(32'hac800000, 16'h0, 16'h0);
      repeat (8300) @(posedge clk);
      poll;
      a = $random(seed);
      fr({8'h20, 3'h0, a[12:0], 8'h0}, 16'h00ff, 16'h00ff);
      fr({8'ha0, 6'h0, a[9:0], 8'h0}, 16'h00ff, 16'h00ff);
      $display("erase done");
      d = $random(seed);
      for (i = 0; i < 2; i++) begin
         fr({8'h40, 8'h0, a[7:6], {6{i[0]}}, d[7:0] ^ i[7:0]}, 16'h0, 16'h0);
         fr({8'h48, 8'h0, a[7:6], {6{i[0]}}, d[15:8]}, 16'h0, 16'h0);
      end
      fr({8'h4c, 3'h0, a[12:6], 14'h0}, 16'h0, 16'h0);
      poll;
      for (i = 0; i < 2; i++) begin
         fr({8'h20, 3'h0, a[12:6], {6{i[0]}}, 8'h0}, 16'h00ff, d[7:0] ^ i[7:0]);
         fr({8'h28, 3'h0, a[12:6], {6{i[0]}}, 8'h0}, 16'h00ff, d[15:8]);
      end
      $display("flash done");
      for (i = 0; i < 2; i++) begin
         fr({8'hc0, 6'h0, a[7:0], 2'b00, d[8*i +: 8]}, 16'h0, 16'h0);
         poll;
      end
      fr({8'hc1, 8'h0, 8'h01, d[7:0]}, 16'h0, 16'h0);
      fr({8'hc2, 6'h0, a[7:0], 2'b00, 8'h0}, 16'h0, 16'h0);
      poll;
      fr({8'ha0, 6'h0, a[7:0], 2'b00, 8'h0}, 16'h00ff, {8'h0, d[15:8]});
      fr({8'ha0, 6'h0, a[7:0], 2'b01, 8'h0}, 16'h00ff, {8'h0, d[7:0]});
      $display("eeprom done");
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         fr({8'hac, 8'(32'he0a4a8a0 >> (8 * i)), 8'h0, v}, 16'h0, 16'h0);
         poll;
         fr({16'(64'h5800500858085000 >> (16 * i)), 16'h0}, 16'h00ff, {8'h0, v});
      end
      for (i = 0; i < 5; i++)
         fr({i < 4 ? 8'h30 : 8'h38, 14'h0, i[1:0], 8'h0}, 16'h00ff,
            {8'h0, 8'(40'h80ff332211 >> (8 * i))});
      v = $random(seed);
      fr({8'h4d, 8'h0, v, 8'h0}, 16'h0, 16'h0);
      repeat (8) @(posedge clk);
      `CHK(ext, v)
      $display("fuse done");
      fr(32'hac800000, 16'h0, 16'h0);
      for (i = 0; i < 3; i++)
         fr(32'hf0000000, 16'h0, 16'h0);
      `CHK(ovr, 1'b1)
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK({enab, oe}, 2'b00)
      repeat (10000) @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      fr(32'hac530000, 16'hff00, 16'h5300);
      repeat (8) @(posedge clk);
      `CHK(enab, 1'b1)
      $display("session done");
      give_verdict;
   end
endmodule
